// ### qct_pkg.sv
/*
  Shared constants and types of the quad counter/timer unit.
  Assumes a 32-bit APB register port and one system clock.
*/
package qct_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CLKCTL  = 8'h00;
  localparam logic [7:0] OFS_MODE01  = 8'h04;
  localparam logic [7:0] OFS_T0CNT   = 8'h08;
  localparam logic [7:0] OFS_T1CNT   = 8'h0C;
  localparam logic [7:0] OFS_T23CTL  = 8'h10;
  localparam logic [7:0] OFS_T2RLD   = 8'h14;
  localparam logic [7:0] OFS_T2CNT   = 8'h18;
  localparam logic [7:0] OFS_T3RLD   = 8'h1C;
  localparam logic [7:0] OFS_T3CNT   = 8'h20;
  localparam logic [7:0] OFS_IRQSTAT = 8'h24;
  localparam logic [7:0] OFS_IRQMASK = 8'h28;

  typedef enum logic [1:0] {MODE13, MODE16, MODE8RL, MODESPLIT} qct_mode_e;

  typedef struct packed {
    logic       timer3HighClockSelect;
    logic       timer3LowClockSelect;
    logic       timer2HighClockSelect;
    logic       timer2LowClockSelect;
    logic       timer1ClockSelect;
    logic       timer0ClockSelect;
    logic [1:0] prescaleField;
  } qct_clkctl_s;

  typedef struct packed {
    logic      t1Run;
    logic      t1Counter;
    qct_mode_e t1Mode;
    logic      t0Run;
    logic      t0Counter;
    qct_mode_e t0Mode;
  } qct_mode_s;

  typedef struct packed {
    logic t3WakeEn;
    logic timer3ExternalClockSelect;
    logic t3Split;
    logic t3Run;
    logic timer2ExternalClockSelect;
    logic t2Split;
    logic t2Run;
  } qct_t23ctl_s;

  typedef struct packed {
    logic t3High;
    logic t3Low;
    logic t2High;
    logic t2Low;
    logic t1Ovf;
    logic t0HighOvf;
    logic t0Ovf;
  } qct_irq_s;

  // reset values
  localparam qct_clkctl_s CLKCTL_RST = '0;
  localparam qct_mode_s   MODE01_RST = '0;
  localparam qct_t23ctl_s T23CTL_RST = '0;
  localparam qct_irq_s    IRQ_RST    = '0;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  // prescaler and clock codes
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [2:0] EXT8_LAST  = 3'h7;
  localparam logic [1:0] PRE_DIV12  = 2'h0;
  localparam logic [1:0] PRE_EXT    = 2'h3;
  localparam logic [7:0]  BYTE_MAX  = 8'hFF;
  localparam logic [15:0] WORD_MAX  = 16'hFFFF;
endpackage

// ### qct_timer_if.sv
/*
  Control and count signals between the unit and one reload timer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface qct_timer_if;
  logic        run;
  logic        split;
  logic        tickLow;
  logic        tickHigh;
  logic [15:0] reloadVal;
  logic        wrCount;
  logic [15:0] wrData;
  logic [15:0] count;
  logic        ovfLow;
  logic        ovfHigh;
  modport ctl (output run, split, tickLow, tickHigh, reloadVal, wrCount,
               wrData, input count, ovfLow, ovfHigh);
  modport tmr (input run, split, tickLow, tickHigh, reloadVal, wrCount,
               wrData, output count, ovfLow, ovfHigh);
endinterface

// ### qct_pin_sync.sv
/*
  Three-stage pin sampler with falling-edge pulse.
  Assumes the pin is asynchronous to clk_sys.
*/
`timescale 1ns/100ps
module qct_pin_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  // pin and edge
  input  wire logic pin,
  output logic      fallEdge
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      level    <= 1'b0;
      fallEdge <= 1'b0;
    end else if (clkEn) begin
      s1       <= pin;
      s2       <= s1;
      s3       <= s2;
      // accepted level changes once stages two and three agree
      if (s2 == s3) begin
        level <= s2;
      end
      fallEdge <= (s2 == s3) && level && !s2;
    end
  end
endmodule

// ### qct_reload_timer.sv
/*
  16-bit or split 8-bit auto-reload timer.
  Assumes tick strobes are already gated by the clock enable.
*/
`timescale 1ns/100ps
module qct_reload_timer (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  // control and count
  qct_timer_if.tmr  tmr
);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tmr.count   <= qct_pkg::WORD_ZERO;
      tmr.ovfLow  <= 1'b0;
      tmr.ovfHigh <= 1'b0;
    end else if (tmr.wrCount) begin
      tmr.count   <= tmr.wrData;
    end else if (clkEn) begin
      tmr.ovfLow  <= 1'b0;
      tmr.ovfHigh <= 1'b0;
      if (tmr.run && !tmr.split && tmr.tickLow) begin
        if (tmr.count == qct_pkg::WORD_MAX) begin
          tmr.count  <= tmr.reloadVal;
          tmr.ovfLow <= 1'b1;
        end else begin
          tmr.count  <= tmr.count + 16'h1;
        end
      end
      if (tmr.run && tmr.split && tmr.tickLow) begin
        if (tmr.count[7:0] == qct_pkg::BYTE_MAX) begin
          tmr.count[7:0] <= tmr.reloadVal[7:0];
          tmr.ovfLow     <= 1'b1;
        end else begin
          tmr.count[7:0] <= tmr.count[7:0] + 8'h1;
        end
      end
      if (tmr.run && tmr.split && tmr.tickHigh) begin
        if (tmr.count[15:8] == qct_pkg::BYTE_MAX) begin
          tmr.count[15:8] <= tmr.reloadVal[15:8];
          tmr.ovfHigh     <= 1'b1;
        end else begin
          tmr.count[15:8] <= tmr.count[15:8] + 8'h1;
        end
      end
    end
  end
endmodule

// ### qct_unit.sv
/*
  Four-channel counter/timer unit with APB registers and interrupt.
  Assumes event and oscillator pins are asynchronous, suspendMode
  comes from logic on clk_sys.
*/
`timescale 1ns/100ps
// Summary of operation
// - four 16-bit counter/timers, two auto-reload
// - timers 0/1: 13-bit, 16-bit, 8-bit reload
// - of timers 0/1, only timer 0 splits into two bytes
// - timers 2/3: 16-bit or two 8-bit reload
// - timer 3 counts external clock in suspend
// - timers 0/1 choose among four clock sources
// - timers 0/1 pick prescaled or system clock
// - timers 2/3: system_clock, system_clock/12, external/8
// - counter increments on event pin falling edge
// - events up to quarter system_clock counted
// - timers raise interrupt requests
// - prescale: /12, /4, /4, external/8
// - clock select ignored in counter operation
// - byte selects: system_clock or external-select clock
module qct_unit (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and power state
  input  wire logic        timer0EventPin,
  input  wire logic        timer1EventPin,
  input  wire logic        extOscPin,
  input  wire logic        suspendMode,
  // requests
  output logic             interrupt,
  output logic             wakeRequest
);
  qct_pkg::qct_clkctl_s clkCtl;
  qct_pkg::qct_mode_s   mode01;
  qct_pkg::qct_t23ctl_s t23Ctl;
  qct_pkg::qct_irq_s    irqStatus;
  qct_pkg::qct_irq_s    irqMask;
  qct_pkg::qct_irq_s    irqSet;
  logic [15:0] t0Count;
  logic [15:0] t1Count;
  logic [15:0] t2Reload;
  logic [15:0] t3Reload;
  logic [3:0]  div12;
  logic [2:0]  ext8Cnt;
  logic        ev0Edge;
  logic        ev1Edge;
  logic        extEdge;
  logic        tick12;
  logic        tick4;
  logic        ext8Tick;
  logic        presTick;
  logic        inc0;
  logic        inc1;
  logic        inc0High;
  logic        t0Split;
  logic [16:0] n0;
  logic [16:0] n1;
  logic        setupPhase;
  logic        wrAcc;
  logic [31:0] next_prdata;
  logic        next_err;

  qct_timer_if t2If ();
  qct_timer_if t3If ();

  // count step of timers 0/1; msb is the overflow
  function automatic logic [16:0] nextCount(
    input qct_pkg::qct_mode_e mode,
    input logic [15:0]        cnt,
    input logic               inc);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    begin
      c13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h1;
      c16 = {1'b0, cnt} + 17'h1;
      c8  = {1'b0, cnt[7:0]} + 9'h1;
      nextCount = {1'b0, cnt};
      if (inc) begin
        case (mode)
          qct_pkg::MODE13: begin
            nextCount = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
          end
          qct_pkg::MODE16: begin
            nextCount = c16;
          end
          qct_pkg::MODE8RL: begin
            nextCount = c8[8] ? {1'b1, cnt[15:8], cnt[15:8]}
                              : {1'b0, cnt[15:8], c8[7:0]};
          end
          default: begin
            nextCount = {c8[8], cnt[15:8], c8[7:0]};
          end
        endcase
      end
    end
  endfunction

  // timer 2/3 byte clock
  function automatic logic tick23(
    input logic sysSel,
    input logic extSel,
    input logic t12,
    input logic te8);
    begin
      tick23 = sysSel ? 1'b1 : (extSel ? te8 : t12);
    end
  endfunction

  qct_pin_sync u_ev0 (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pin      (timer0EventPin),
    .fallEdge (ev0Edge)
  );

  qct_pin_sync u_ev1 (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pin      (timer1EventPin),
    .fallEdge (ev1Edge)
  );

  qct_pin_sync u_ext (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pin      (extOscPin),
    .fallEdge (extEdge)
  );

  // system clock /12 and /4 prescaler
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div12 <= '0;
    end else if (clkEn) begin
      div12 <= (div12 == qct_pkg::DIV12_LAST) ? '0 : div12 + 4'h1;
    end
  end

  // external clock /8, synchronised to system clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext8Cnt <= '0;
    end else if (clkEn && extEdge) begin
      ext8Cnt <= ext8Cnt + 3'h1;
    end
  end

  assign tick12   = clkEn && (div12 == qct_pkg::DIV12_LAST);
  assign tick4    = clkEn && (div12[1:0] == qct_pkg::DIV4_LAST);
  assign ext8Tick = clkEn && extEdge && (ext8Cnt == qct_pkg::EXT8_LAST);

  always_comb begin
    case (clkCtl.prescaleField)
      qct_pkg::PRE_DIV12: presTick = tick12;
      qct_pkg::PRE_EXT:   presTick = ext8Tick;
      default:            presTick = tick4;
    endcase
  end

  // timers 0/1 increment enables
  assign t0Split  = (mode01.t0Mode == qct_pkg::MODESPLIT);
  assign inc0 = clkEn && !suspendMode && mode01.t0Run
    && (mode01.t0Counter ? ev0Edge
        : (clkCtl.timer0ClockSelect ? 1'b1 : presTick));
  assign inc1 = clkEn && !suspendMode && mode01.t1Run
    && (mode01.t1Mode != qct_pkg::MODESPLIT)
    && (mode01.t1Counter ? ev1Edge
        : (clkCtl.timer1ClockSelect ? 1'b1 : presTick));
  // split high byte runs as a timer under the timer 1 run bit
  assign inc0High = clkEn && !suspendMode && t0Split && mode01.t1Run
    && (clkCtl.timer0ClockSelect ? 1'b1 : presTick);
  assign n0 = nextCount(mode01.t0Mode, t0Count, inc0);
  assign n1 = nextCount(mode01.t1Mode, t1Count, inc1);

  // apb phase decode
  assign setupPhase = psel && !penable && !pready;
  assign wrAcc      = psel && penable && pready && pwrite;

  // timer 0 count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      t0Count <= qct_pkg::WORD_ZERO;
    end else if (wrAcc && paddr == qct_pkg::OFS_T0CNT) begin
      t0Count <= pwdata[15:0];
    end else if (clkEn) begin
      t0Count[7:0] <= n0[7:0];
      if (!t0Split) begin
        t0Count[15:8] <= n0[15:8];
      end else if (inc0High) begin
        t0Count[15:8] <= t0Count[15:8] + 8'h1;
      end
    end
  end

  // timer 1 count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      t1Count <= qct_pkg::WORD_ZERO;
    end else if (wrAcc && paddr == qct_pkg::OFS_T1CNT) begin
      t1Count <= pwdata[15:0];
    end else if (clkEn) begin
      t1Count <= n1[15:0];
    end
  end

  // timers 2 and 3
  assign t2If.run       = t23Ctl.t2Run;
  assign t2If.split     = t23Ctl.t2Split;
  assign t2If.reloadVal = t2Reload;
  assign t2If.wrCount   = wrAcc && (paddr == qct_pkg::OFS_T2CNT);
  assign t2If.wrData    = pwdata[15:0];
  assign t2If.tickLow   = clkEn && !suspendMode
    && tick23(clkCtl.timer2LowClockSelect,
              t23Ctl.timer2ExternalClockSelect, tick12, ext8Tick);
  assign t2If.tickHigh  = clkEn && !suspendMode
    && tick23(clkCtl.timer2HighClockSelect,
              t23Ctl.timer2ExternalClockSelect, tick12, ext8Tick);
  assign t3If.run       = t23Ctl.t3Run;
  assign t3If.split     = t23Ctl.t3Split;
  assign t3If.reloadVal = t3Reload;
  assign t3If.wrCount   = wrAcc && (paddr == qct_pkg::OFS_T3CNT);
  assign t3If.wrData    = pwdata[15:0];
  // in suspend only the external clock survives
  assign t3If.tickLow   = clkEn && (suspendMode ? ext8Tick
    : tick23(clkCtl.timer3LowClockSelect,
             t23Ctl.timer3ExternalClockSelect, tick12, ext8Tick));
  assign t3If.tickHigh  = clkEn && (suspendMode ? ext8Tick
    : tick23(clkCtl.timer3HighClockSelect,
             t23Ctl.timer3ExternalClockSelect, tick12, ext8Tick));

  qct_reload_timer u_t2 (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .tmr     (t2If)
  );

  qct_reload_timer u_t3 (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .tmr     (t3If)
  );

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clkCtl   <= qct_pkg::CLKCTL_RST;
      mode01   <= qct_pkg::MODE01_RST;
      t23Ctl   <= qct_pkg::T23CTL_RST;
      t2Reload <= qct_pkg::WORD_ZERO;
      t3Reload <= qct_pkg::WORD_ZERO;
      irqMask  <= qct_pkg::IRQ_RST;
    end else if (wrAcc) begin
      case (paddr)
        qct_pkg::OFS_CLKCTL:  clkCtl   <= pwdata[7:0];
        qct_pkg::OFS_MODE01:  mode01   <= pwdata[7:0];
        qct_pkg::OFS_T23CTL:  t23Ctl   <= pwdata[6:0];
        qct_pkg::OFS_T2RLD:   t2Reload <= pwdata[15:0];
        qct_pkg::OFS_T3RLD:   t3Reload <= pwdata[15:0];
        qct_pkg::OFS_IRQMASK: irqMask  <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_comb begin
    irqSet           = qct_pkg::IRQ_RST;
    irqSet.t0Ovf     = clkEn && n0[16];
    irqSet.t0HighOvf = inc0High && (t0Count[15:8] == qct_pkg::BYTE_MAX);
    irqSet.t1Ovf     = clkEn && n1[16];
    irqSet.t2Low     = clkEn && t2If.ovfLow;
    irqSet.t2High    = clkEn && t2If.ovfHigh;
    irqSet.t3Low     = clkEn && t3If.ovfLow;
    irqSet.t3High    = clkEn && t3If.ovfHigh;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStatus <= qct_pkg::IRQ_RST;
    end else if (wrAcc && paddr == qct_pkg::OFS_IRQSTAT) begin
      irqStatus <= (irqStatus & ~pwdata[6:0]) | irqSet;
    end else begin
      irqStatus <= irqStatus | irqSet;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interrupt <= 1'b0;
    end else begin
      interrupt <= |(irqStatus & irqMask);
    end
  end

  // wake request held until suspend ends
  always_ff @(posedge clk_sys) begin
    if (reset || !suspendMode) begin
      wakeRequest <= 1'b0;
    end else if (t23Ctl.t3WakeEn && (irqSet.t3Low || irqSet.t3High)) begin
      wakeRequest <= 1'b1;
    end
  end

  // read mux and unmapped answer
  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    case (paddr)
      qct_pkg::OFS_CLKCTL:  next_prdata = 32'(clkCtl);
      qct_pkg::OFS_MODE01:  next_prdata = 32'(mode01);
      qct_pkg::OFS_T0CNT:   next_prdata = 32'(t0Count);
      qct_pkg::OFS_T1CNT:   next_prdata = 32'(t1Count);
      qct_pkg::OFS_T23CTL:  next_prdata = 32'(t23Ctl);
      qct_pkg::OFS_T2RLD:   next_prdata = 32'(t2Reload);
      qct_pkg::OFS_T2CNT:   next_prdata = 32'(t2If.count);
      qct_pkg::OFS_T3RLD:   next_prdata = 32'(t3Reload);
      qct_pkg::OFS_T3CNT:   next_prdata = 32'(t3If.count);
      qct_pkg::OFS_IRQSTAT: next_prdata = 32'(irqStatus);
      qct_pkg::OFS_IRQMASK: next_prdata = 32'(irqMask);
      default:              next_err    = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      if (setupPhase) begin
        prdata  <= pwrite ? '0 : next_prdata;
        pslverr <= next_err;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_apbAnswer;
    setupPhase |=> pready ##1 !pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer)
    else $error("apb access not answered in one cycle");

  property p_eventCount;
    inc0 && mode01.t0Counter && mode01.t0Mode == qct_pkg::MODE16
      && !wrAcc && t0Count != qct_pkg::WORD_MAX
      |=> t0Count == $past(t0Count) + 16'h1;
  endproperty
  a_eventCount: assert property (p_eventCount)
    else $error("event edge did not increment timer 0");

  property p_counterIgnoresSel;
    clkEn && mode01.t0Counter && !ev0Edge && !wrAcc && !inc0High
      |=> $stable(t0Count);
  endproperty
  a_counterIgnoresSel: assert property (p_counterIgnoresSel)
    else $error("timer 0 counted without an event edge");

  property p_sysClkCount;
    clkEn && !suspendMode && mode01.t1Run && !mode01.t1Counter
      && clkCtl.timer1ClockSelect && mode01.t1Mode == qct_pkg::MODE16
      && !wrAcc && t1Count != qct_pkg::WORD_MAX
      |=> t1Count == $past(t1Count) + 16'h1;
  endproperty
  a_sysClkCount: assert property (p_sysClkCount)
    else $error("timer 1 missed a system clock count");

  property p_noSplitT1;
    mode01.t1Mode == qct_pkg::MODESPLIT && !wrAcc |=> $stable(t1Count);
  endproperty
  a_noSplitT1: assert property (p_noSplitT1)
    else $error("timer 1 counted in split mode");

  property p_reload8;
    inc0 && mode01.t0Mode == qct_pkg::MODE8RL
      && t0Count[7:0] == qct_pkg::BYTE_MAX && !wrAcc
      |=> t0Count[7:0] == t0Count[15:8] && irqStatus.t0Ovf;
  endproperty
  a_reload8: assert property (p_reload8)
    else $error("8-bit reload or overflow flag wrong");

  property p_div12;
    tick12 |=> !tick12 [*8];
  endproperty
  a_div12: assert property (p_div12)
    else $error("prescaler ticked early");

  property p_edgePulse;
    ev0Edge && clkEn |=> !ev0Edge;
  endproperty
  a_edgePulse: assert property (p_edgePulse)
    else $error("event edge pulse longer than one cycle");

  property p_irqOut;
    |(irqStatus & irqMask) |=> interrupt;
  endproperty
  a_irqOut: assert property (p_irqOut)
    else $error("interrupt not raised for unmasked status");

  property p_suspendT3;
    suspendMode && ext8Tick && t23Ctl.t3Run && !t23Ctl.t3Split
      && !t3If.wrCount && t3If.count != qct_pkg::WORD_MAX
      |=> t3If.count == $past(t3If.count) + 16'h1;
  endproperty
  a_suspendT3: assert property (p_suspendT3)
    else $error("timer 3 did not count in suspend");

  c_t0Ovf: cover property (inc0 && n0[16]);
  c_wake: cover property (!wakeRequest ##1 wakeRequest);
  c_t2Split: cover property (t23Ctl.t2Split && t2If.ovfHigh);
endmodule

// ### qct_pin_model.sv
/*
  Pin model: event pins and external oscillator of the timer unit.
  Assumes it runs on the unit's system clock.
*/
`timescale 1ns/100ps
module qct_pin_model (
  // clock
  input  wire logic clk_sys,
  // pins, idle high
  output logic      timer0EventPin,
  output logic      timer1EventPin,
  output logic      extOscPin
);
  logic [2:0] pins = 3'h7;

  assign timer0EventPin = pins[0];
  assign timer1EventPin = pins[1];
  assign extOscPin      = pins[2];

  // n falls on one pin, two cycles per level
  task automatic pulses(input int sel, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk_sys);
      pins[sel] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      pins[sel] <= 1'b1;
    end
  endtask
endmodule

// ### quad_counter_timer_unit_tb_top.sv
/*
  Self-checking bench of the counter/timer unit over APB.
  Assumes the pin model drives the event and oscillator pins.
*/
`timescale 1ns/100ps
module quad_counter_timer_unit_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        suspendMode = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer0EventPin;
  logic        timer1EventPin;
  logic        extOscPin;
  logic        interrupt;
  logic        wakeRequest;
  logic [31:0] q;
  logic        err;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [31:0] st[4] = '{32'hFF1F, 32'hFFFF, 32'h40FF, 32'h00FF};
  logic [31:0] af[4] = '{32'h0, 32'h0, 32'h4040, 32'h0};
  logic [31:0] ck[4] = '{32'h01, 32'h02, 32'h00, 32'h04};
  int          wt[4] = '{40, 40, 48, 20};
  logic [31:0] lo[4] = '{32'h9, 32'h9, 32'h3, 32'h16};
  logic [31:0] hi[4] = '{32'hC, 32'hC, 32'h6, 32'h18};
  logic [31:0] c2[4] = '{32'h10, 32'h00, 32'h30, 32'h00};
  logic [31:0] t2[4] = '{32'h01, 32'h01, 32'h03, 32'h05};
  logic [31:0] f2[4] = '{32'h08, 32'h08, 32'h18, 32'h00};
  logic [31:0] mk[4] = '{32'h08, 32'h00, 32'h18, 32'h08};

  qct_unit dut_u (
    .clk_sys, .reset, .clkEn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer0EventPin,
    .timer1EventPin, .extOscPin, .suspendMode, .interrupt,
    .wakeRequest
  );

  qct_pin_model pm_u (
    .clk_sys, .timer0EventPin, .timer1EventPin, .extOscPin
  );

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] l, h, got);
    checks_done++;
    if ((got >= l && got <= h) !== 1'b1) begin
      fail_count++;
      $display("unexpected %s expected %h..%h seen %h", nm, l, h, got);
    end
  endtask

  // one transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] l, h);
    apb(1'b0, a, 32'h0);
    chk(nm, l, h, q);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a <= 40; a += 4) begin
      rd("reset value", 8'(a), 32'h0, 32'h0);
    end
    wr(8'h2C, 32'hFF);
    chk("unmapped error", 32'h1, 32'h1, {31'h0, err});
    rd("unmapped data", 8'h2C, 32'h0, 32'h0);
    // one event at the rollover of each timer 0 mode
    for (int m = 0; m < 4; m++) begin
      wr(8'h24, 32'h7F);
      wr(8'h04, 32'h0C | m);
      wr(8'h08, st[m]);
      pm_u.pulses(0, 1);
      repeat (8) @(posedge clk_sys);
      rd("t0 count", 8'h08, af[m], af[m]);
      rd("t0 flag", 8'h24, 32'h1, 32'h1);
    end
    // events at quarter rate, timer 0 clock select set but ignored
    wr(8'h00, 32'h04);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'hDD);
    fork
      pm_u.pulses(0, 7);
      pm_u.pulses(1, 3);
    join
    repeat (8) @(posedge clk_sys);
    rd("t0 events", 8'h08, 32'h7, 32'h7);
    rd("t1 events", 8'h0C, 32'h3, 32'h3);
    // timer 1 in the split mode holds
    wr(8'h00, 32'h08);
    wr(8'h04, 32'hB0);
    wr(8'h0C, 32'h1234);
    repeat (20) @(posedge clk_sys);
    rd("t1 split", 8'h0C, 32'h1234, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h00, ck[i]);
      wr(8'h04, 32'h09);
      repeat (wt[i]) @(posedge clk_sys);
      wr(8'h04, 32'h01);
      rd("t0 ticks", 8'h08, lo[i], hi[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h24, 32'h7F);
      wr(8'h28, mk[i]);
      wr(8'h14, 32'h80F0);
      wr(8'h18, 32'hFFFF);
      wr(8'h00, c2[i]);
      wr(8'h10, t2[i]);
      repeat (40) @(posedge clk_sys);
      wr(8'h10, 32'h0);
      rd("t2 flags", 8'h24, f2[i], f2[i]);
      chk("irq", {31'h0, (f2[i] & mk[i]) != 0},
          {31'h0, (f2[i] & mk[i]) != 0}, {31'h0, interrupt});
    end
    wr(8'h24, 32'h7F);
    @(posedge clk_sys);
    chk("irq cleared", 32'h0, 32'h0, {31'h0, interrupt});
    // timer 3 wakes the device from suspend
    wr(8'h28, 32'h0);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'hFFFF);
    suspendMode <= 1'b1;
    wr(8'h10, 32'h68);
    pm_u.pulses(2, 20);
    repeat (8) @(posedge clk_sys);
    chk("wake", 32'h1, 32'h1, {31'h0, wakeRequest});
    rd("t3 flag", 8'h24, 32'h20, 32'h20);
    suspendMode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("wake clear", 32'h0, 32'h0, {31'h0, wakeRequest});
    // clock enable low freezes a running timer
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h04);
    wr(8'h04, 32'h09);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rd("t0 frozen", 8'h08, 32'h1, 32'h1);
    clkEn <= 1'b1;
    // prescaler on external clock /8
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h03);
    wr(8'h04, 32'h09);
    pm_u.pulses(2, 16);
    repeat (8) @(posedge clk_sys);
    rd("t0 ext ticks", 8'h08, 32'h2, 32'h2);
    end_of_test();
  end
endmodule
